// *** core/sicap_core.sv ***
// Strap capture and image identity readback registers.
// Assumes strap pins are static around reset and a serial host drives the register port.
`timescale 1ns/10ps
`include "sicap_map.svh"

// Functional notes
// (R1) Latch strap values at reset release; hold until next reset.
// (R2) Record mode strap: 0 soft-pin, 1 hard-pin.
// (R3) In hard-pin mode store six strap pins in bits 7:2.
// (R4) Hard-pin field equals pin pattern directly, no translation.
// (R5) In soft-pin mode hard-pin field reads zero.
// (R6) Target address sits in bits 7:1, bit 0 reserved.
// (R7) Address initialised from non-volatile memory, default 0x54.
// (R8) Soft-pin: three-level strap sets low bits 0, 1 or 3.
// (R9) Hard-pin: low two address bits zero, strap ignored.
// (R10) Upper five address bits come from software-writable volatile copy.
// (R11) Image revision loads from non-volatile or fixed ROM image.
// (R12) Image revision reloads after reset and after each commit.
// (R13) Readback registers read-only; writes ignored; reserved bits zero.
// (R14) Host reads only after loading finishes to see settled values.
module sicap_core #(
	parameter logic [3:0] SETTLE_CYCLES = `SICAP_SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Strap pins from the board
	input  wire logic       mode_strap_pin,
	input  wire logic [5:0] hard_strap_pin,
	input  wire logic       addr_strap_high,
	input  wire logic       addr_strap_mid,
	// Non-volatile memory image
	input  wire logic [6:0] nvm_target_address,
	input  wire logic [7:0] nvm_image_revision,
	input  wire logic [7:0] rom_image_revision,
	input  wire logic       use_rom_image,
	input  wire logic       nvm_valid,
	input  wire logic       commit_done,
	// Volatile copy of upper address bits
	input  wire logic       addr_upper_wr,
	input  wire logic [4:0] addr_upper_wdata,
	// Register port
	input  wire logic       reg_rd,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// Status
	output logic            config_loaded,
	output logic      [6:0] target_address_field,
	output logic            config_mode_select
);

	// Sequencer states
	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_LOAD,
		ST_RUN
	} sicap_state_t;

	// Sequencer
	sicap_state_t            state_q;
	sicap_state_t            state_d;
	logic [3:0]              settle_q;
	logic [3:0]              settle_d;
	logic                    capture_now;
	logic                    load_now;
	logic                    image_take;
	// Synchronised straps and register request
	sicap_pkg::sicap_strap_t strap_s;
	sicap_pkg::sicap_req_t   req;
	logic                    rd_take;
	// Captured straps
	logic                    mode_q;
	logic [5:0]              hard_strap_pattern_q;
	logic [5:0]              hard_strap_pattern_d;
	logic [1:0]              addr_low_q;
	logic [1:0]              addr_low_d;
	// Address and revision
	logic [4:0]              addr_upper_q;
	logic [4:0]              addr_upper_d;
	logic [7:0]              image_revision_q;
	logic [7:0]              image_revision_d;
	logic                    reload_pend_q;
	logic                    reload_pend_d;
	// Readback views
	logic [7:0]              hard_strap_readback;
	logic [7:0]              serial_target_address;
	logic [7:0]              rdata_d;
	logic                    rvalid_d;

	// Strap pins enter through a two-flop synchroniser
	sicap_sync #(
		.WIDTH(9)
	) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.pin_async({mode_strap_pin, hard_strap_pin, addr_strap_high, addr_strap_mid}),
		.pin_sync (strap_s)
	);

	// Register port request as one bundle
	assign req = '{rd: reg_rd, wr: reg_wr, addr: reg_addr, wdata: reg_wdata};

	// A read is taken only without a write beside it
	assign rd_take = req.rd && !req.wr; // see (R13)

	// Last settle cycle: synchroniser has flushed its reset value
	assign capture_now = (state_q == ST_SETTLE) && (settle_q >= SETTLE_CYCLES); // see (R1)

	// Address image taken in the load state
	assign load_now = (state_q == ST_LOAD) && nvm_valid; // see (R7)

	// Revision taken when pending and the image is valid, outside the settle state
	assign image_take = reload_pend_q && nvm_valid && (state_q != ST_SETTLE); // see (R12)

	// Next state: settle after release, take straps once, then run
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_SETTLE: begin
				if (capture_now) begin
					state_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (nvm_valid) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_SETTLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= ST_SETTLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Settle count, frozen once the straps are taken
	always_comb begin
		settle_d = settle_q;
		if (state_q == ST_SETTLE && !capture_now) begin
			settle_d = settle_q + 4'h1;
		end
	end

	// Settle counter
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			settle_q <= 4'h0;
		end else begin
			settle_q <= settle_d;
		end
	end

	// Mode strap, taken once per reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode_q <= 1'b0;
		end else if (capture_now) begin
			mode_q <= strap_s.mode; // see (R2)
		end
	end

	// Hard pattern per pin, zero in soft-pin mode
	for (genvar b = 0; b < 6; b++) begin : g_hard_bit
		assign hard_strap_pattern_d[b] = strap_s.mode & strap_s.hard_pattern[b]; // see (R3) see (R4) see (R5)
	end

	// Hard pattern, held until the next reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hard_strap_pattern_q <= 6'h00;
		end else if (capture_now) begin
			hard_strap_pattern_q <= hard_strap_pattern_d; // see (R1)
		end
	end

	// Three-level address strap decode; high wins over mid
	always_comb begin
		addr_low_d = `SICAP_TRI_LOW;
		if (strap_s.mode == sicap_pkg::SICAP_HARD_PIN) begin
			addr_low_d = 2'h0; // see (R9)
		end else if (strap_s.addr_high) begin
			addr_low_d = `SICAP_TRI_HIGH; // see (R8)
		end else if (strap_s.addr_mid) begin
			addr_low_d = `SICAP_TRI_MID; // see (R8)
		end else begin
			addr_low_d = `SICAP_TRI_LOW; // see (R8)
		end
	end

	// Low address bits, held until the next reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_low_q <= 2'h0;
		end else if (capture_now) begin
			addr_low_q <= addr_low_d; // see (R1)
		end
	end

	// Upper address bits: memory image on load, then software copy
	always_comb begin
		addr_upper_d = addr_upper_q;
		if (load_now) begin
			addr_upper_d = nvm_target_address[6:2]; // see (R7)
		end else if (state_q == ST_RUN && addr_upper_wr) begin
			addr_upper_d = addr_upper_wdata; // see (R10)
		end
	end

	// Upper address register, factory default out of reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_upper_q <= 5'(`SICAP_ADDR_DEFAULT >> 2); // see (R7)
		end else begin
			addr_upper_q <= addr_upper_d;
		end
	end

	// Reload pending; a commit wins over a clear in the same cycle
	always_comb begin
		reload_pend_d = reload_pend_q;
		if (commit_done) begin
			reload_pend_d = 1'b1; // see (R12)
		end else if (nvm_valid && state_q != ST_SETTLE) begin
			reload_pend_d = 1'b0;
		end
	end

	// Reload pending flag, armed by reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reload_pend_q <= 1'b1;
		end else begin
			reload_pend_q <= reload_pend_d;
		end
	end

	// Revision source select
	always_comb begin
		image_revision_d = image_revision_q;
		if (image_take) begin
			image_revision_d = use_rom_image ? rom_image_revision : nvm_image_revision; // see (R11)
		end
	end

	// Image revision register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			image_revision_q <= `SICAP_REV_RESET;
		end else begin
			image_revision_q <= image_revision_d; // see (R12)
		end
	end

	// Readback views, reserved bits zero
	assign hard_strap_readback   = mode_q ? {hard_strap_pattern_q, 2'b00} : `SICAP_HARD_RESET; // see (R5) see (R13)
	assign serial_target_address = {addr_upper_q, addr_low_q, 1'b0}; // see (R6) see (R13)

	// Read decode; writes are never stored
	always_comb begin
		rdata_d = 8'h00;
		case (req.addr)
			`SICAP_ADDR_HARD_STRAP: begin
				rdata_d = hard_strap_readback;
			end
			`SICAP_ADDR_TARGET_ADDR: begin
				rdata_d = serial_target_address;
			end
			`SICAP_ADDR_IMAGE_REV: begin
				rdata_d = image_revision_q;
			end
			default: begin
				rdata_d = 8'h00; // see (R13)
			end
		endcase
	end

	// Answer strobe follows a taken read
	assign rvalid_d = rd_take;

	// Answer strobe, one cycle after the request
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= rvalid_d;
		end
	end

	// Read data, held until the next read
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (rd_take) begin
			reg_rdata <= rdata_d;
		end
	end

	// Status outputs
	assign config_loaded        = (state_q == ST_RUN) && !reload_pend_q; // see (R14)
	assign target_address_field = serial_target_address[`SICAP_ADDR_FIELD_MSB:`SICAP_ADDR_FIELD_LSB];
	assign config_mode_select   = mode_q;

endmodule : sicap_core

// *** core/sicap_sync.sv ***
// Two-flop synchroniser for a group of strap pins.
// Assumes pins are quasi-static levels from the board.
`timescale 1ns/10ps
module sicap_sync #(
	parameter int WIDTH = 9
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Levels
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_sync
);

	logic [WIDTH-1:0] meta_q;

	// First stage read only by the second
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_q   <= '0;
			pin_sync <= '0;
		end else begin
			meta_q   <= pin_async;
			pin_sync <= meta_q;
		end
	end

endmodule : sicap_sync

// *** include/sicap_map.svh ***
// Offsets, field positions, reset values and timing counts of the strap capture block.
// Assumes inclusion by bare name from the core module; the package does not include it.
`ifndef SICAP_MAP_SVH
`define SICAP_MAP_SVH

// Register indices on the serial register port
`define SICAP_ADDR_HARD_STRAP   8'h09
`define SICAP_ADDR_TARGET_ADDR  8'h0A
`define SICAP_ADDR_IMAGE_REV    8'h0B

// Field positions
`define SICAP_HARD_FIELD_MSB    7
`define SICAP_HARD_FIELD_LSB    2
`define SICAP_ADDR_FIELD_MSB    7
`define SICAP_ADDR_FIELD_LSB    1

// Reset and default values
`define SICAP_HARD_RESET        8'h00
`define SICAP_REV_RESET         8'h00
`define SICAP_ADDR_DEFAULT      7'h54

// Three-level strap decode
`define SICAP_TRI_LOW           2'h0
`define SICAP_TRI_MID           2'h1
`define SICAP_TRI_HIGH          2'h3

// Cycles to wait after reset release before sampling settled straps
`define SICAP_SETTLE_CYCLES     4'h3

`endif

// *** include/sicap_pkg.sv ***
// Types shared by the strap capture block.
// Assumes sicap_map.svh is on the include path.
package sicap_pkg;

	// Mode selector captured from the mode strap
	typedef enum logic {
		SICAP_SOFT_PIN = 1'b0,
		SICAP_HARD_PIN = 1'b1
	} sicap_mode_t;

	// Synchronised strap levels
	typedef struct packed {
		logic       mode;
		logic [5:0] hard_pattern;
		logic       addr_high;
		logic       addr_mid;
	} sicap_strap_t;

	// Register port request
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sicap_req_t;

endpackage : sicap_pkg

// *** verif/sicap_board.sv ***
// Board model: strap levels and a non-volatile image that becomes valid late.
// Assumes the bench sets the wanted levels and lag.
`timescale 1ns/10ps
module sicap_board (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Wanted levels and image lag
	input wire sicap_pkg::sicap_strap_t strap,
	input wire logic [3:0] nvm_lag,
	// Board pins and image status
	output logic mode_strap_pin,
	output logic [5:0] hard_strap_pin,
	output logic addr_strap_high,
	output logic addr_strap_mid,
	output logic nvm_valid
);
	logic [3:0] cnt_q;
	// Straps are plain board levels
	assign {mode_strap_pin, hard_strap_pin, addr_strap_high, addr_strap_mid} = strap;
	// Lag counter from reset release
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cnt_q <= 4'h0;
		else if (cnt_q != nvm_lag)
			cnt_q <= cnt_q + 4'h1;
	end
	// Image valid only once the lag has run out
	assign nvm_valid = rst_n && (cnt_q == nvm_lag);
endmodule : sicap_board

// *** verif/sicap_chk.sv ***
// Port assertions for the strap capture core.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/10ps
module sicap_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Watched ports
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic config_loaded,
	input wire logic [6:0] target_address_field,
	input wire logic config_mode_select
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Read request, then its answer
	sequence rd_take;
		reg_rd && !reg_wr;
	endsequence
	sequence ans_of(a);
		reg_rvalid && $past(reg_addr) == a;
	endsequence
	chk_read_answer: assert property (rd_take |=> reg_rvalid) else $error("read not answered");
	chk_answer_cause: assert property (reg_rvalid |-> $past(reg_rd) && !$past(reg_wr)) else $error("stray answer");
	chk_write_silent: assert property (reg_wr |=> !reg_rvalid) else $error("write answered");
	chk_mode_held: assert property (config_loaded |=> $stable(config_mode_select)) else $error("mode moved");
	chk_hard_low: assert property (
		config_loaded && config_mode_select |-> target_address_field[1:0] == 2'h0) else $error("low bits set");
	chk_addr_read: assert property (
		ans_of(8'h0A) |-> reg_rdata == {$past(target_address_field), 1'h0}) else $error("address read wrong");
	chk_hard_read: assert property (
		ans_of(8'h09) |-> reg_rdata[1:0] == 2'h0 && ($past(config_mode_select) || reg_rdata == 8'h00))
		else $error("hard field wrong");
	chk_unmapped_zero: assert property (
		reg_rvalid && ($past(reg_addr) < 8'h09 || $past(reg_addr) > 8'h0B) |-> reg_rdata == 8'h00)
		else $error("unmapped not zero");
endmodule : sicap_chk
bind sicap_core sicap_chk sicap_chk_inst (.mclk, .rst_n, .reg_rd, .reg_wr, .reg_addr, .reg_rdata, .reg_rvalid,
	.config_loaded, .target_address_field, .config_mode_select);

// *** verif/tb.sv ***
// Self-checking bench for the strap capture core.
// Assumes the board model supplies straps and image status.
`timescale 1ns/10ps
module tb;
	logic mclk, rst_n, mode_strap_pin, addr_strap_high, addr_strap_mid, nvm_valid, use_rom_image, commit_done;
	logic addr_upper_wr, reg_rd, reg_wr, reg_rvalid, config_loaded, config_mode_select;
	logic [5:0] hard_strap_pin;
	logic [4:0] addr_upper_wdata;
	logic [7:0] nvm_image_revision, reg_addr, reg_wdata, reg_rdata;
	logic [6:0] target_address_field;
	logic [3:0] nvm_lag;
	logic [1:0] low;
	int bad_count, compares, n;
	sicap_pkg::sicap_strap_t strap;
	sicap_pkg::sicap_strap_t tbl [5] = '{'{1'h1, 6'h3F, 1'h1, 1'h0}, '{1'h1, 6'h2A, 1'h0, 1'h1},
		'{1'h0, 6'h3F, 1'h0, 1'h0}, '{1'h0, 6'h15, 1'h0, 1'h1}, '{1'h0, 6'h3F, 1'h1, 1'h1}};
	sicap_board sicap_board_inst (.mclk, .rst_n, .strap, .nvm_lag, .mode_strap_pin, .hard_strap_pin,
		.addr_strap_high, .addr_strap_mid, .nvm_valid);
	sicap_core sicap_core_inst (.mclk, .rst_n, .mode_strap_pin, .hard_strap_pin,
		.addr_strap_high, .addr_strap_mid, .nvm_target_address(7'h54), .nvm_image_revision,
		.rom_image_revision(8'hC3), .use_rom_image, .nvm_valid, .commit_done, .addr_upper_wr, .addr_upper_wdata,
		.reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .config_loaded, .target_address_field,
		.config_mode_select);
	// Compare and count
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		chk({reg_rvalid, reg_rdata}, {1'h1, e});
	endtask : rd_chk
	task automatic wr(input logic [7:0] a);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= 8'hFF;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic wait_loaded();
		n = 0;
		do begin
			@(posedge mclk);
			#1;
		end while (config_loaded !== 1'h1 && ++n < 60);
		chk({8'h00, config_loaded}, 9'h001);
	endtask : wait_loaded
	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// Clock
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	// Watchdog
	initial begin
		#100000;
		bad_count++;
		final_report();
	end
	// Strap cases, then software address copy and commit reload
	initial begin
		{rst_n, reg_rd, reg_wr, commit_done, addr_upper_wr, use_rom_image} = 6'h00;
		{reg_addr, reg_wdata, addr_upper_wdata} = 21'h0;
		nvm_image_revision = 8'h11;
		for (int i = 0; i < 5; i++) begin
			strap <= tbl[i];
			nvm_lag <= 4'(3 * i);
			use_rom_image <= i[0];
			rst_n <= 1'h0;
			repeat (8) @(posedge mclk);
			rst_n <= 1'h1;
			wait_loaded();
			low = tbl[i].mode ? 2'h0 : {tbl[i].addr_high, tbl[i].addr_high | tbl[i].addr_mid};
			chk({8'h00, config_mode_select}, {8'h00, tbl[i].mode});
			rd_chk(8'h09, tbl[i].mode ? {tbl[i].hard_pattern, 2'h0} : 8'h00);
			rd_chk(8'h0A, {5'h15, low, 1'h0});
			rd_chk(8'h0B, i[0] ? 8'hC3 : 8'h11);
			strap <= ~tbl[i];
			wr(8'h09);
			wr(8'h0A);
			rd_chk(8'h09, tbl[i].mode ? {tbl[i].hard_pattern, 2'h0} : 8'h00);
			rd_chk(8'h0A, {5'h15, low, 1'h0});
			rd_chk(8'h08, 8'h00);
			rd_chk(8'h0C, 8'h00);
		end
		@(posedge mclk);
		addr_upper_wr <= 1'h1;
		addr_upper_wdata <= 5'h0A;
		@(posedge mclk);
		addr_upper_wr <= 1'h0;
		nvm_image_revision <= 8'h5A;
		commit_done <= 1'h1;
		@(posedge mclk);
		commit_done <= 1'h0;
		wait_loaded();
		rd_chk(8'h0A, {5'h0A, low, 1'h0});
		rd_chk(8'h0B, 8'h5A);
		final_report();
	end
endmodule : tb
